// [hdl/hbg_device_end.sv]
// device end: uart with 1040-byte rx and tx fifos, flow control and
// fractional baud generator; assumes link inputs are asynchronous
//
// Functional notes
// - four wires: rx, tx, rts, cts
// - rates from 57600 bps to 6 mbps
// - host expects at most 750 kbps at boot
// - 1040-byte receive and transmit fifos
// - h4 framing, packet-type byte leads packet
// - both ends start at 115.2 kbaud
// - uart clock 24 mhz default, 48 mhz max; the code assumes a 25 mhz sys_clk
// - divisor divides clock in multiples of 16
// - up to eight stuffed cycles per half
// - host may reprogram divisor and adjustment live
// - combined rate error within plus minus five percent
// - 24 mhz: 3m and 2m high-rate settings
// - 48 mhz: 6m high-rate, 115200 normal settings
`timescale 1ns/1ps
`default_nettype none
module hbg_device_end
	import hbg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	hbg_link_if.device link,
	input wire logic cfg_we,
	input wire logic [7:0] cfg_divisor,
	input wire logic [7:0] cfg_adjust,
	input wire logic cfg_high_rate,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic rx_frame_err,
	output logic rx_overrun
);

	logic [7:0] baud_divisor_value;
	logic [7:0] baud_stuffing_adjust;
	logic high_rate;
	logic [TIMER_W-1:0] bit_period;
	logic [TIMER_W-1:0] bit_mid;

	logic rxd_s1, rxd_s2, rxd_prev;
	logic cts_s1, cts_s2;

	logic [7:0] txf_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] txf_wr, txf_rd, txf_count;
	logic [7:0] rxf_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] rxf_wr, rxf_rd, rxf_count;

	hbg_state_t tx_state, rx_state;
	logic [TIMER_W-1:0] tx_timer, rx_timer;
	logic [2:0] tx_bits, rx_bits;
	logic [7:0] tx_shift, rx_shift;
	logic txd;
	logic rts_n;
	logic tx_push, tx_pop, rx_push, rx_pop, rx_done;

	// live rate change; a byte in flight picks up the new timing at its
	// next bit, so software should change rates between packets
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			baud_divisor_value <= RST_DIVISOR;
			baud_stuffing_adjust <= RST_ADJUST;
			high_rate <= RST_HIGH_RATE;
		end
		else if (cfg_we)
		begin
			baud_divisor_value <= cfg_divisor;
			baud_stuffing_adjust <= cfg_adjust;
			high_rate <= cfg_high_rate;
		end
	end

	assign bit_period = hbg_period(baud_divisor_value, baud_stuffing_adjust,
		high_rate);
	// centre sampling leaves half a bit of slack for the combined rate error
	assign bit_mid = hbg_mid(baud_divisor_value, baud_stuffing_adjust,
		high_rate);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
			rxd_prev <= 1'b1;
			cts_s1 <= 1'b1;
			cts_s2 <= 1'b1;
		end
		else
		begin
			rxd_s1 <= link.host_txd;
			rxd_s2 <= rxd_s1;
			rxd_prev <= rxd_s2;
			cts_s1 <= link.host_rts_n;
			cts_s2 <= cts_s1;
		end
	end

	// transmit fifo; bytes, including the h4 type byte, go out in order
	assign tx_ready = (txf_count != FIFO_FULL);
	assign tx_push = tx_valid && tx_ready;
	assign tx_pop = (tx_state == HBG_IDLE) && (txf_count != '0)
		&& !cts_s2;

	always_ff @(posedge sys_clk)
	begin
		if (tx_push)
			txf_mem[txf_wr] <= tx_data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			txf_wr <= '0;
			txf_rd <= '0;
			txf_count <= '0;
		end
		else
		begin
			if (tx_push)
				txf_wr <= hbg_next_ptr(txf_wr);
			if (tx_pop)
				txf_rd <= hbg_next_ptr(txf_rd);
			if (tx_push && !tx_pop)
				txf_count <= txf_count + 11'h1;
			else if (tx_pop && !tx_push)
				txf_count <= txf_count - 11'h1;
		end
	end

	// cts is checked only between bytes; a byte once started completes
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			tx_state <= HBG_IDLE;
			tx_timer <= '0;
			tx_bits <= '0;
			tx_shift <= '0;
			txd <= 1'b1;
		end
		else
		begin
			case (tx_state)
				HBG_IDLE:
				begin
					txd <= 1'b1;
					if (tx_pop)
					begin
						tx_shift <= txf_mem[txf_rd];
						txd <= 1'b0;
						tx_timer <= bit_period - 13'h1;
						tx_state <= HBG_START;
					end
				end
				HBG_START, HBG_DATA:
				begin
					if (tx_timer != '0)
						tx_timer <= tx_timer - 13'h1;
					else
					begin
						tx_timer <= bit_period - 13'h1;
						if (tx_state == HBG_DATA && tx_bits == LAST_DATA_BIT)
						begin
							txd <= 1'b1;
							tx_state <= HBG_STOP;
						end
						else
						begin
							txd <= tx_shift[0];
							tx_shift <= {1'b0, tx_shift[7:1]};
							tx_bits <= (tx_state == HBG_START) ? 3'h0
								: tx_bits + 3'h1;
							tx_state <= HBG_DATA;
						end
					end
				end
				HBG_STOP:
				begin
					if (tx_timer != '0)
						tx_timer <= tx_timer - 13'h1;
					else
						tx_state <= HBG_IDLE;
				end
				default:
					tx_state <= HBG_IDLE;
			endcase
		end
	end

	// receiver samples at the centre of each bit, stuffing included
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rx_state <= HBG_IDLE;
			rx_timer <= '0;
			rx_bits <= '0;
			rx_shift <= '0;
			rx_done <= 1'b0;
			rx_frame_err <= 1'b0;
		end
		else
		begin
			rx_done <= 1'b0;
			rx_frame_err <= 1'b0;
			case (rx_state)
				HBG_IDLE:
				begin
					if (rxd_prev && !rxd_s2)
					begin
						rx_timer <= bit_mid - 13'h1;
						rx_state <= HBG_START;
					end
				end
				HBG_START:
				begin
					if (rx_timer != '0)
						rx_timer <= rx_timer - 13'h1;
					else if (rxd_s2)
						rx_state <= HBG_IDLE; // glitch, not a start bit
					else
					begin
						rx_timer <= bit_period - 13'h1;
						rx_bits <= '0;
						rx_state <= HBG_DATA;
					end
				end
				HBG_DATA:
				begin
					if (rx_timer != '0)
						rx_timer <= rx_timer - 13'h1;
					else
					begin
						rx_timer <= bit_period - 13'h1;
						rx_shift <= {rxd_s2, rx_shift[7:1]};
						rx_bits <= rx_bits + 3'h1;
						if (rx_bits == LAST_DATA_BIT)
							rx_state <= HBG_STOP;
					end
				end
				HBG_STOP:
				begin
					if (rx_timer != '0)
						rx_timer <= rx_timer - 13'h1;
					else
					begin
						rx_done <= rxd_s2;
						rx_frame_err <= !rxd_s2;
						rx_state <= HBG_IDLE;
					end
				end
				default:
					rx_state <= HBG_IDLE;
			endcase
		end
	end

	// receive fifo; a byte arriving while full is dropped and flagged
	assign rx_push = rx_done && (rxf_count != FIFO_FULL);
	assign rx_valid = (rxf_count != '0);
	assign rx_pop = rx_valid && rx_ready;
	assign rx_data = rxf_mem[rxf_rd];

	always_ff @(posedge sys_clk)
	begin
		if (rx_push)
			rxf_mem[rxf_wr] <= rx_shift;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rxf_wr <= '0;
			rxf_rd <= '0;
			rxf_count <= '0;
			rx_overrun <= 1'b0;
			rts_n <= 1'b1;
		end
		else
		begin
			rx_overrun <= rx_done && !rx_push;
			if (rx_push)
				rxf_wr <= hbg_next_ptr(rxf_wr);
			if (rx_pop)
				rxf_rd <= hbg_next_ptr(rxf_rd);
			if (rx_push && !rx_pop)
				rxf_count <= rxf_count + 11'h1;
			else if (rx_pop && !rx_push)
				rxf_count <= rxf_count - 11'h1;
			// margin covers bytes already in flight at the host
			rts_n <= (rxf_count >= RTS_STOP_LEVEL);
		end
	end

	assign link.dev_txd = txd;
	assign link.dev_rts_n = rts_n;

endmodule
`default_nettype wire

// [hdl/hbg_host_end.sv]
// host end: single-byte uart with flow control and the same baud
// generator; assumes link inputs are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module hbg_host_end
	import hbg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	hbg_link_if.host link,
	input wire logic cfg_we,
	input wire logic [7:0] cfg_divisor,
	input wire logic [7:0] cfg_adjust,
	input wire logic cfg_high_rate,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic rx_frame_err
);

	logic [7:0] div, adj;
	logic hr;
	logic [TIMER_W-1:0] bit_period, bit_mid;
	logic rxd_s1, rxd_s2, rxd_prev, cts_s1, cts_s2;
	hbg_state_t tx_state, rx_state;
	logic [TIMER_W-1:0] tx_timer, rx_timer;
	logic [2:0] tx_bits, rx_bits;
	logic [7:0] tx_shift, rx_shift;
	logic txd;

	// rate change is issued by the host user after the vendor command
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			div <= RST_DIVISOR;
			adj <= RST_ADJUST;
			hr <= RST_HIGH_RATE;
		end
		else if (cfg_we)
		begin
			div <= cfg_divisor;
			adj <= cfg_adjust;
			hr <= cfg_high_rate;
		end
	end

	assign bit_period = hbg_period(div, adj, hr);
	assign bit_mid = hbg_mid(div, adj, hr);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			{rxd_s1, rxd_s2, rxd_prev} <= 3'h7;
			{cts_s1, cts_s2} <= 2'h3;
		end
		else
		begin
			rxd_s1 <= link.dev_txd;
			rxd_s2 <= rxd_s1;
			rxd_prev <= rxd_s2;
			cts_s1 <= link.dev_rts_n;
			cts_s2 <= cts_s1;
		end
	end

	// one byte at a time, only while the device grants cts
	assign tx_ready = (tx_state == HBG_IDLE) && !cts_s2;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			tx_state <= HBG_IDLE;
			tx_timer <= '0;
			tx_bits <= '0;
			tx_shift <= '0;
			txd <= 1'b1;
		end
		else
		begin
			case (tx_state)
				HBG_IDLE:
				begin
					txd <= 1'b1;
					if (tx_valid && tx_ready)
					begin
						tx_shift <= tx_data;
						txd <= 1'b0;
						tx_timer <= bit_period - 13'h1;
						tx_state <= HBG_START;
					end
				end
				HBG_START, HBG_DATA:
				begin
					if (tx_timer != '0)
						tx_timer <= tx_timer - 13'h1;
					else
					begin
						tx_timer <= bit_period - 13'h1;
						if (tx_state == HBG_DATA && tx_bits == LAST_DATA_BIT)
						begin
							txd <= 1'b1;
							tx_state <= HBG_STOP;
						end
						else
						begin
							txd <= tx_shift[0];
							tx_shift <= {1'b0, tx_shift[7:1]};
							tx_bits <= (tx_state == HBG_START) ? 3'h0
								: tx_bits + 3'h1;
							tx_state <= HBG_DATA;
						end
					end
				end
				HBG_STOP:
				begin
					if (tx_timer != '0)
						tx_timer <= tx_timer - 13'h1;
					else
						tx_state <= HBG_IDLE;
				end
				default:
					tx_state <= HBG_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rx_state <= HBG_IDLE;
			rx_timer <= '0;
			rx_bits <= '0;
			rx_shift <= '0;
			rx_valid <= 1'b0;
			rx_data <= '0;
			rx_frame_err <= 1'b0;
		end
		else
		begin
			rx_frame_err <= 1'b0;
			if (rx_valid && rx_ready)
				rx_valid <= 1'b0;
			case (rx_state)
				HBG_IDLE:
					if (rxd_prev && !rxd_s2)
					begin
						rx_timer <= bit_mid - 13'h1;
						rx_state <= HBG_START;
					end
				HBG_START:
					if (rx_timer != '0)
						rx_timer <= rx_timer - 13'h1;
					else if (rxd_s2)
						rx_state <= HBG_IDLE;
					else
					begin
						rx_timer <= bit_period - 13'h1;
						rx_bits <= '0;
						rx_state <= HBG_DATA;
					end
				HBG_DATA:
					if (rx_timer != '0)
						rx_timer <= rx_timer - 13'h1;
					else
					begin
						rx_timer <= bit_period - 13'h1;
						rx_shift <= {rxd_s2, rx_shift[7:1]};
						rx_bits <= rx_bits + 3'h1;
						if (rx_bits == LAST_DATA_BIT)
							rx_state <= HBG_STOP;
					end
				HBG_STOP:
					if (rx_timer != '0)
						rx_timer <= rx_timer - 13'h1;
					else
					begin
						rx_frame_err <= !rxd_s2;
						if (rxd_s2)
						begin
							rx_valid <= 1'b1;
							rx_data <= rx_shift;
						end
						rx_state <= HBG_IDLE;
					end
				default:
					rx_state <= HBG_IDLE;
			endcase
		end
	end

	// rts low only while the holding byte is free; the device keeps at
	// most the byte already in flight, which overwrites on a late read
	assign link.host_rts_n = rx_valid;
	assign link.host_txd = txd;

endmodule
`default_nettype wire

// [hdl/hbg_link_if.sv]
// the four uart wires between the device end and the host end
// assumes both ends run on the same sys_clk; txd lines idle high, rts_n lines idle low
`timescale 1ns/1ps
`default_nettype none
interface hbg_link_if;
	logic dev_txd;
	logic host_txd;
	logic dev_rts_n;
	logic host_rts_n;

	modport device (
		output dev_txd,
		output dev_rts_n,
		input host_txd,
		input host_rts_n
	);
	modport host (
		output host_txd,
		output host_rts_n,
		input dev_txd,
		input dev_rts_n
	);
endinterface
`default_nettype wire

// [hdl/hbg_pkg.sv]
// constants, types and bit-timing functions shared by both ends of the link
// assumes one system clock that also serves as the uart bit clock
package hbg_pkg;

	localparam int CLK_HZ = 25_000_000;
	localparam int DEFAULT_BAUD = 115_200;
	localparam int FIFO_DEPTH = 1040;
	localparam int PTR_W = 11;
	localparam int NEAR_FULL_MARGIN = 16;
	localparam logic [PTR_W-1:0] FIFO_LAST = 11'(FIFO_DEPTH - 1);
	localparam logic [PTR_W-1:0] FIFO_FULL = 11'(FIFO_DEPTH);
	localparam logic [PTR_W-1:0] RTS_STOP_LEVEL =
		11'(FIFO_DEPTH - NEAR_FULL_MARGIN);
	localparam int TIMER_W = 13;
	localparam logic [3:0] STUFF_MAX = 4'h8;
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;
	// reset rate: 16*13 + 4 + 5 = 217 clocks, about 115.2 kbaud at 25 mhz
	localparam logic [7:0] RST_DIVISOR = 8'h0c;
	localparam logic [7:0] RST_ADJUST = 8'h45;
	localparam logic RST_HIGH_RATE = 1'b0;
	// h4 packet-type indicator bytes, sent first in every packet
	localparam logic [7:0] H4_COMMAND = 8'h01;
	localparam logic [7:0] H4_ACL = 8'h02;
	localparam logic [7:0] H4_SCO = 8'h03;
	localparam logic [7:0] H4_EVENT = 8'h04;

	typedef enum logic [1:0] {HBG_IDLE, HBG_START, HBG_DATA, HBG_STOP}
		hbg_state_t;

	function automatic logic [TIMER_W-1:0] hbg_clip(input logic [3:0] n);
		hbg_clip = (n > STUFF_MAX) ? 13'(STUFF_MAX) : 13'(n);
	endfunction

	// normal: 16*(div+1) plus stuffing in first half and at the end
	// high rate: 256 - adjust clocks per bit, divisor ignored
	function automatic logic [TIMER_W-1:0] hbg_period(
		input logic [7:0] div, input logic [7:0] adj, input logic hr);
		if (hr)
			hbg_period = 13'(9'h100 - {1'b0, adj});
		else
			hbg_period = 13'({div, 4'h0}) + 13'h10 + hbg_clip(adj[7:4])
				+ hbg_clip(adj[3:0]);
	endfunction

	// clocks from start edge to the centre of the start bit
	function automatic logic [TIMER_W-1:0] hbg_mid(
		input logic [7:0] div, input logic [7:0] adj, input logic hr);
		if (hr)
			hbg_mid = hbg_period(div, adj, hr) >> 1;
		else
			hbg_mid = 13'({div, 3'h0}) + 13'h8 + hbg_clip(adj[7:4]);
	endfunction

	function automatic logic [PTR_W-1:0] hbg_next_ptr(
		input logic [PTR_W-1:0] p);
		hbg_next_ptr = (p == FIFO_LAST) ? '0 : p + 11'h1;
	endfunction

endpackage

// [test/hbg_link_chk.sv]
// assertions on the four link wires between the two uart ends
// assumes both ends share sys_clk and are given the same rate settings
`timescale 1ns/1ps
`default_nettype none
module hbg_link_chk
	import hbg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic dev_txd,
	input wire logic host_txd,
	input wire logic dev_rts_n,
	input wire logic host_rts_n,
	input wire logic cfg_we,
	input wire logic [7:0] cfg_divisor,
	input wire logic [7:0] cfg_adjust,
	input wire logic cfg_high_rate
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	int per;
	logic [1:0] ln;
	assign ln = {host_txd, dev_txd};
	function automatic int clip(input logic [3:0] n);
		return (n > 4'h8) ? 8 : int'(n);
	endfunction
	// rate is only changed between frames, so one period covers a frame
	always_ff @(posedge sys_clk)
		if (srst)
			per <= 217;
		else if (cfg_we)
			per <= cfg_high_rate ? 256 - int'(cfg_adjust) :
				16 * int'(cfg_divisor) + 16 + clip(cfg_adjust[7:4])
				+ clip(cfg_adjust[3:0]);
	for (genvar g = 0; g < 2; g++)
	begin : trk
		logic busy;
		int cnt;
		always_ff @(posedge sys_clk)
			if (srst)
			begin
				busy <= 1'b0;
				cnt <= 0;
			end
			else if (!busy)
			begin
				busy <= !ln[g];
				cnt <= 1;
			end
			else if (cnt == 10 * per - 1)
				busy <= 1'b0;
			else
				cnt <= cnt + 1;
		a_start_low: assert property (busy && cnt < per |-> !ln[g])
			else $error("start bit length wrong");
		a_bit_steady: assert property
			(busy && (cnt % per) != 0 |-> $stable(ln[g]))
			else $error("line moved inside a bit");
		a_stop_high: assert property
			(busy && cnt >= 9 * per |-> ln[g])
			else $error("stop bit not high");
		a_idle_gap: assert property
			(busy && cnt == 10 * per - 1 |=> ln[g])
			else $error("no idle cycle after frame");
	end
	sequence s_cts_held;
		(host_rts_n && !trk[0].busy) [*6];
	endsequence
	a_cts_blocks: assert property (s_cts_held |=> dev_txd)
		else $error("device started while host not ready");
	a_idle_reset: assert property
		($fell(srst) |-> dev_txd && host_txd)
		else $error("line not idle out of reset");
	a_rts_reset: assert property
		($fell(srst) |=> !dev_rts_n && !host_rts_n)
		else $error("rts not open after reset");
endmodule
`default_nettype wire

// [test/test_hci_uart_baud_generator.sv]
// self-checking bench: device end and host end joined by the link
// assumes a 25 mhz sys_clk; both ends always get the same settings
`timescale 1ns/1ps
`default_nettype none
module test_hci_uart_baud_generator import hbg_pkg::*;;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic cfg_we = 1'b0;
	logic [7:0] cfg_divisor = 8'h00;
	logic [7:0] cfg_adjust = 8'h00;
	logic cfg_high_rate = 1'b0;
	logic d_tv = 1'b0, h_tv = 1'b0, d_rr = 1'b1, h_rr = 1'b1;
	logic [7:0] d_td = 8'h00, h_td = 8'h00, d_rd, h_rd;
	logic d_tr, h_tr, d_rv, h_rv;
	logic d_fe, h_fe, d_ov;
	int errors = 0, num_checks = 0;
	int flags = 0;
	hbg_link_if u_hbg_link_if();
	hbg_device_end u_hbg_device_end(.sys_clk(sys_clk), .srst(srst),
		.link(u_hbg_link_if.device), .cfg_we(cfg_we),
		.cfg_divisor(cfg_divisor), .cfg_adjust(cfg_adjust),
		.cfg_high_rate(cfg_high_rate), .tx_valid(d_tv), .tx_ready(d_tr),
		.tx_data(d_td), .rx_valid(d_rv), .rx_ready(d_rr), .rx_data(d_rd),
		.rx_frame_err(d_fe), .rx_overrun(d_ov));
	hbg_host_end u_hbg_host_end(.sys_clk(sys_clk), .srst(srst),
		.link(u_hbg_link_if.host), .cfg_we(cfg_we),
		.cfg_divisor(cfg_divisor), .cfg_adjust(cfg_adjust),
		.cfg_high_rate(cfg_high_rate), .tx_valid(h_tv), .tx_ready(h_tr),
		.tx_data(h_td), .rx_valid(h_rv), .rx_ready(h_rr), .rx_data(h_rd),
		.rx_frame_err(h_fe));
	// clean traffic must never raise a framing or overrun pulse
	always @(posedge sys_clk)
		if (!srst && {d_fe, h_fe, d_ov} !== 3'h0)
			flags++;
	hbg_link_chk u_hbg_link_chk(.sys_clk(sys_clk), .srst(srst),
		.dev_txd(u_hbg_link_if.dev_txd), .host_txd(u_hbg_link_if.host_txd),
		.dev_rts_n(u_hbg_link_if.dev_rts_n),
		.host_rts_n(u_hbg_link_if.host_rts_n), .cfg_we(cfg_we),
		.cfg_divisor(cfg_divisor), .cfg_adjust(cfg_adjust),
		.cfg_high_rate(cfg_high_rate));
	initial
	begin
		forever #20 sys_clk = ~sys_clk;
	end
	task tick;
		@(posedge sys_clk);
		#1;
	endtask
	task check(input string what, input logic [15:0] exp, got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// every wait is bounded; a stuck end ends the run here
	task wait_on(input logic sig, inout int n);
		n++;
		tick;
		if (n > 9000)
		begin
			errors++;
			$display("mismatch wait expected %h seen timeout", sig);
			stop_test;
		end
	endtask
	function automatic int cl(input logic [3:0] n);
		return (n > 4'h8) ? 8 : int'(n);
	endfunction
	function automatic int exp_per(input logic [7:0] d, a, input logic hr);
		return hr ? 256 - int'(a) : 16 * int'(d) + 16 + cl(a[7:4]) + cl(a[3:0]);
	endfunction
	task automatic send(input logic dev, input logic [7:0] b);
		int n = 0;
		while ((dev ? d_tr : h_tr) !== 1'b1)
			wait_on(1'b1, n);
		d_tv = dev;
		h_tv = !dev;
		d_td = b;
		h_td = b;
		tick;
		d_tv = 1'b0;
		h_tv = 1'b0;
	endtask
	task automatic recv(input logic at_host, input logic [7:0] b);
		int n = 0;
		while ((at_host ? h_rv : d_rv) !== 1'b1)
			wait_on(1'b1, n);
		check("rx data", b, at_host ? h_rd : d_rd);
		tick;
	endtask
	// start bit low time in clocks; sent bytes have bit 0 set
	task automatic xfer(input logic dev, input logic [7:0] b, input int p);
		int n = 0;
		int w = 0;
		send(dev, b);
		while ((dev ? u_hbg_link_if.dev_txd : u_hbg_link_if.host_txd) !== 1'b0)
			wait_on(1'b0, w);
		while ((dev ? u_hbg_link_if.dev_txd : u_hbg_link_if.host_txd) === 1'b0)
			wait_on(1'b0, n);
		check("start bit clocks", 16'(p), 16'(n));
		recv(dev, b);
		// let the stop bit finish so a rate change never cuts a frame
		repeat (p) tick;
	endtask
	task t_reset;
		check("dev_txd", 16'h1, 16'(u_hbg_link_if.dev_txd));
		check("host_txd", 16'h1, 16'(u_hbg_link_if.host_txd));
		check("dev_rts_n", 16'h0, 16'(u_hbg_link_if.dev_rts_n));
		check("host_rts_n", 16'h0, 16'(u_hbg_link_if.host_rts_n));
	endtask
	task automatic t_rates;
		logic [16:0] tbl [6] = '{{8'h0c, 8'h45, 1'b0},
			{8'hff, 8'hf8, 1'b1}, {8'hff, 8'hf4, 1'b1},
			{8'h01, 8'he6, 1'b0}, {8'h00, 8'h00, 1'b0},
			{8'h05, 8'h05, 1'b0}};
		int p = exp_per(RST_DIVISOR, RST_ADJUST, RST_HIGH_RATE);
		// boot traffic stays at the slow reset rate
		xfer(1'b0, H4_COMMAND, p);
		foreach (tbl[i])
		begin
			{cfg_divisor, cfg_adjust, cfg_high_rate} = tbl[i];
			cfg_we = 1'b1;
			tick;
			cfg_we = 1'b0;
			tick;
			p = exp_per(cfg_divisor, cfg_adjust, cfg_high_rate);
			xfer(1'b0, H4_COMMAND, p);
			xfer(1'b1, H4_SCO, p);
		end
		// a second reset must bring back the default rate
		srst = 1'b1;
		repeat (2) tick;
		srst = 1'b0;
		tick;
		xfer(1'b1, H4_COMMAND, exp_per(8'h0c, 8'h45, 1'b0));
	endtask
	task automatic t_burst;
		logic [7:0] v [4] = '{H4_EVENT, 8'h0e, 8'h04, 8'h01};
		d_tv = 1'b1;
		foreach (v[i])
		begin
			d_td = v[i];
			tick;
		end
		d_tv = 1'b0;
		foreach (v[i])
			recv(1'b1, v[i]);
	endtask
	task automatic t_flow;
		int n = 0;
		h_rr = 1'b0;
		send(1'b1, 8'h5a);
		tick;
		send(1'b1, 8'ha5);
		recv(1'b1, 8'h5a);
		repeat (3000)
		begin
			tick;
			n += int'(u_hbg_link_if.dev_txd !== 1'b1);
		end
		check("low clocks while held", 16'h0, 16'(n));
		check("host_rts_n held", 16'h1, 16'(u_hbg_link_if.host_rts_n));
		h_rr = 1'b1;
		tick;
		recv(1'b1, 8'ha5);
		check("error flag cycles", 16'h0, 16'(flags));
	endtask
	initial
	begin
		repeat (5) tick;
		srst = 1'b0;
		repeat (2) tick;
		t_reset;
		t_rates;
		t_burst;
		t_flow;
		stop_test;
	end
endmodule
`default_nettype wire
